// File: shared/amc_regs.vh
// register map, field layout, reset values and limits of the axis motion configuration block
`ifndef AMC_REGS_VH
`define AMC_REGS_VH

// ============================================================
// per-axis register offsets: base + axis * stride; status register at one fixed address
`define AMC_DIV_BASE        12'h000
`define AMC_RATE_BASE       12'h020
`define AMC_DIRN_BASE       12'h040
`define AMC_HOME_BASE       12'h060
`define AMC_HOFS_BASE       12'h080
`define AMC_HOLD_BASE       12'h0A0
`define AMC_STAT_ADDR       12'h0C0
`define AMC_AXIS_STRIDE     12'h004

// ============================================================
// reset values
`define AMC_DIV_RST         8'h14
`define AMC_RATE_RST        10'h014
`define AMC_DIRN_RST        1'b0
`define AMC_HOME_RST        3'h1
`define AMC_HOFS_RST        27'h0000000
`define AMC_HOLD_RST        1'b1

// ============================================================
// limits and units
`define AMC_RATE_MAX        10'h3E8
`define AMC_HOME_MAX        3'h6
`define AMC_HOFS_MAX        27'h5F5E0FF
// 0.5 mm expressed in 0.01 um units
`define AMC_HOFS_DEFAULT    27'h000C350

// ============================================================
// status bits
`define AMC_STAT_REJ_BIT    0

`endif

// File: testbench/amc_axis_motion_config_assertions.sv
// assertion checker for the axis motion configuration block
`timescale 1ns/10ps
module amc_checker #(
    parameter NUM_AXES = 8
) (
    // clock, reset and bus
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // axis side
    input wire logic                  estop_n,
    input wire logic [NUM_AXES-1:0]   winding_on_ff,
    input wire logic [NUM_AXES-1:0]   homing_enable_ff,
    input wire logic [NUM_AXES*8-1:0] step_div_ff,
    input wire logic [NUM_AXES*10-1:0] step_rate_ff,
    input wire logic [NUM_AXES*27-1:0] home_offset_ff,
    input wire logic [NUM_AXES*3-1:0] home_method_ff
);
    // ============================================================
    // bus and settings
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence access_s; psel && penable && !pready; endsequence
    sequence clear_s; estop_n [*6]; endsequence
    ready_answer_a: assert property (access_s |=> pready) else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    // a store lands at the answer edge and reaches the outputs one edge later
    write_stable_a: assert property (!$past(pready && pwrite && !pslverr, 2) |->
        $stable(step_div_ff) && $stable(step_rate_ff)) else $error("setting changed without write");
    winding_on_a: assert property (clear_s |-> &winding_on_ff) else $error("windings off without estop");
    for (genvar a = 0; a < NUM_AXES; a++) begin : g_ax
        wire [2:0]  m = home_method_ff[a*3+:3];
        wire [26:0] o = home_offset_ff[a*27+:27];
        home_enable_a: assert property (homing_enable_ff[a] == (m != 3'h0)) else $error("homing enable");
        offset_gate_a: assert property (!(m inside {3'h1, 3'h5, 3'h6}) |-> o == 27'h0) else $error("offset gate");
        offset_floor_a: assert property ($past(presetn) && m inside {3'h1, 3'h5, 3'h6} |->
            o != 27'h0 && o <= 27'h5F5E0FF) else $error("offset zero or too large");
        div_legal_a: assert property (step_div_ff[a*8+:8] inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0A,
            8'h14, 8'h19, 8'h28, 8'h32, 8'h50, 8'h64, 8'h7D, 8'hC8, 8'hFA}) else $error("illegal division");
        rate_range_a: assert property (step_rate_ff[a*10+:10] inside {[10'h001:10'h3E8]}) else $error("rate range");
    end
endmodule // amc_checker

bind amc_axis_motion_config amc_checker #(.NUM_AXES(NUM_AXES)) u_amc_checker (.pclk, .presetn, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .estop_n, .winding_on_ff, .homing_enable_ff, .step_div_ff, .step_rate_ff,
    .home_offset_ff, .home_method_ff);

// File: testbench/amc_stage_model.sv
// stage model: counts microsteps per axis in the driven direction
`timescale 1ns/10ps
module amc_stage_model #(
    parameter NUM_AXES = 8
) (
    // clock, reset and step tick
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                step,
    // driver controls
    input wire logic [NUM_AXES-1:0] motor_dir_ff,
    input wire logic [NUM_AXES-1:0] winding_on_ff,
    // position
    output logic signed [15:0]      pos [NUM_AXES]
);
    // ============================================================
    // an unpowered winding cannot hold or move the rotor
    always @(posedge pclk or negedge presetn)
        for (int a = 0; a < NUM_AXES; a++)
            if (!presetn)
                pos[a] <= '0;
            else if (step && winding_on_ff[a])
                pos[a] <= pos[a] + (motor_dir_ff[a] ? 16'sd1 : -16'sd1);
endmodule // amc_stage_model

// File: testbench/test_axis_motion_config.sv
// self-checking bench for the axis motion configuration block
`timescale 1ns/10ps
`include "amc_regs.vh"
module test_axis_motion_config;
    // ============================================================
    // signals
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, estop_n = 1, step = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, q;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  move_positive = 8'hFF;
    logic        e;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    wire  [7:0]  motor_dir_ff, winding_on_ff, homing_enable_ff;
    wire  [63:0] step_div_ff;
    wire  [79:0] step_rate_ff;
    wire  [215:0] home_offset_ff;
    wire  [23:0] home_method_ff;
    logic signed [15:0] pos [8];
    logic [7:0]  dv [15] = '{1, 2, 4, 5, 8, 10, 20, 25, 40, 50, 80, 100, 125, 200, 250};
    int bad_count = 0, check_count = 0, cyc = 0;
    always #50 pclk = ~pclk;
    amc_axis_motion_config #(.NUM_AXES(8)) u_amc_axis_motion_config (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .move_positive, .estop_n, .motor_dir_ff,
        .winding_on_ff, .homing_enable_ff, .step_div_ff, .step_rate_ff, .home_offset_ff, .home_method_ff);
    amc_stage_model #(.NUM_AXES(8)) u_amc_stage_model (.pclk, .presetn, .step, .motor_dir_ff, .winding_on_ff, .pos);
    // ============================================================
    // bus and compare tasks
    function automatic logic [11:0] ad(logic [11:0] b, int a);
        return b + `AMC_AXIS_STRIDE * a[11:0];
    endfunction
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    // pready is read right after the edge, so it is the value that edge sampled
    task automatic apb(logic [11:0] a, logic [31:0] d, logic w);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwdata <= d;
        pwrite <= w;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never gets an answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, logic x);
        apb(a, d, 1'b1);
        chk("pslverr", 32'(x), 32'(e));
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] x);
        apb(a, 32'h0, 1'b0);
        chk("prdata", x, q);
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset();
        repeat (2) @(posedge pclk);
        for (int a = 0; a < 8; a++) begin
            chk("div", 32'h14, 32'(step_div_ff[a*8+:8]));
            chk("rate", 32'h14, 32'(step_rate_ff[a*10+:10]));
            chk("offset", 32'(`AMC_HOFS_DEFAULT), 32'(home_offset_ff[a*27+:27]));
        end
        chk("winding", 32'hFF, 32'(winding_on_ff));
        chk("homing", 32'hFF, 32'(homing_enable_ff));
        chk("dir", 32'hFF, 32'(motor_dir_ff));
    endtask
    task automatic t_div();
        foreach (dv[i]) begin
            wr(ad(`AMC_DIV_BASE, i % 8), 32'(dv[i]), 1'b0);
            repeat (2) @(posedge pclk);
            chk("div", 32'(dv[i]), 32'(step_div_ff[(i%8)*8+:8]));
        end
        wr(ad(`AMC_DIV_BASE, 0), 32'h3, 1'b1);
        rd(ad(`AMC_DIV_BASE, 0), 32'(dv[8]));
    endtask
    task automatic t_rate();
        wr(ad(`AMC_RATE_BASE, 5), 32'h3E8, 1'b0);
        wr(ad(`AMC_RATE_BASE, 5), 32'h3E9, 1'b1);
        wr(ad(`AMC_RATE_BASE, 6), 32'h0, 1'b1);
        wr(ad(`AMC_RATE_BASE, 6), 32'h1, 1'b0);
        pstrb <= 4'h3;
        wr(ad(`AMC_RATE_BASE, 5), 32'h7, 1'b1);
        pstrb <= 4'hF;
        repeat (2) @(posedge pclk);
        chk("rate", 32'h3E8, 32'(step_rate_ff[50+:10]));
        chk("rate", 32'h1, 32'(step_rate_ff[60+:10]));
        rd(`AMC_STAT_ADDR, 32'h1);
        wr(`AMC_STAT_ADDR, 32'h1, 1'b0);
        rd(`AMC_STAT_ADDR, 32'h0);
        rd(12'h0C4, 32'h0);
        chk("pslverr", 32'h1, 32'(e));
    endtask
    task automatic t_dir();
        wr(ad(`AMC_DIRN_BASE, 2), 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        chk("dir", 32'hFB, 32'(motor_dir_ff));
        step <= 1'b1;
        repeat (3) @(posedge pclk);
        step <= 1'b0;
        move_positive <= 8'h00;
        repeat (2) @(posedge pclk);
        chk("pos", 32'h3, 32'(pos[0]));
        chk("pos", 32'hFFFFFFFD, 32'(pos[2]));
        chk("dir", 32'h04, 32'(motor_dir_ff));
    endtask
    task automatic t_home();
        wr(ad(`AMC_HOFS_BASE, 3), 32'd1234, 1'b0);
        for (int m = 0; m < 7; m++) begin
            wr(ad(`AMC_HOME_BASE, 3), 32'(m), 1'b0);
            repeat (2) @(posedge pclk);
            chk("homing", 32'(m != 0), 32'(homing_enable_ff[3]));
            chk("method", 32'(m), 32'(home_method_ff[9+:3]));
            chk("offset", (m == 1 || m == 5 || m == 6) ? 32'd1234 : 32'd0, 32'(home_offset_ff[81+:27]));
        end
        wr(ad(`AMC_HOME_BASE, 3), 32'h7, 1'b1);
        wr(ad(`AMC_HOFS_BASE, 3), 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        chk("offset", 32'(`AMC_HOFS_DEFAULT), 32'(home_offset_ff[81+:27]));
        wr(ad(`AMC_HOFS_BASE, 3), 32'd99999999, 1'b0);
        wr(ad(`AMC_HOFS_BASE, 3), 32'd100000000, 1'b1);
        repeat (2) @(posedge pclk);
        chk("offset", 32'd99999999, 32'(home_offset_ff[81+:27]));
    endtask
    task automatic t_estop();
        wr(ad(`AMC_HOLD_BASE, 4), 32'h0, 1'b0);
        estop_n <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("winding", 32'hEF, 32'(winding_on_ff));
        estop_n <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("winding", 32'hFF, 32'(winding_on_ff));
    endtask
    // ============================================================
    // run control
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_div();
        t_rate();
        t_dir();
        t_home();
        t_estop();
        finish_test();
    end
endmodule // test_axis_motion_config

// File: verilog/amc_axis_cmd.v
// per-axis step direction, offset selection and estop winding control
`timescale 1ns/10ps
`include "amc_regs.vh"
module amc_axis_cmd (
    // settings
    input  wire        rotation_negative,
    input  wire [2:0]  homing_method_select,
    input  wire [26:0] homing_offset,
    input  wire        estop_winding_hold,
    // live inputs
    input  wire        move_positive,
    input  wire        estop,
    // results
    output wire        motor_dir,
    output wire        homing_enable,
    output wire        offset_used,
    output wire [26:0] offset_eff,
    output wire        winding_on
);

    // a positive move turns the motor the other way when negative is selected
    assign motor_dir     = move_positive ^ rotation_negative;
    assign homing_enable = (homing_method_select != 3'h0);
    assign offset_used   = (homing_method_select == 3'h1) ||
                           (homing_method_select == 3'h5) ||
                           (homing_method_select == 3'h6);
    assign offset_eff    = !offset_used ? 27'h0000000 :
                           (homing_offset == 27'h0000000) ? `AMC_HOFS_DEFAULT : homing_offset;
    assign winding_on    = !estop || estop_winding_hold;

endmodule // amc_axis_cmd

// File: verilog/amc_axis_motion_config.v
// eight-axis motion configuration register file with APB slave
`timescale 1ns/10ps
`include "amc_regs.vh"
// Operation
// - each axis accepts one of fifteen division factors and uses it for stepping
// - each axis holds travel per full step, 1 to 1000 tenths of micrometre
// - positive move maps to positive or negative rotation per direction setting
// - homing selector: 0 disables, 1 to 6 select a homing procedure
// - homing offset 0 to 99999999, applied only for methods 1, 5, 6
// - offset setting zero means a fixed half millimetre offset
// - per-axis setting keeps or drops winding current on emergency stop
// - independent copy of every setting for each of eight axes
// - settings retained and used as operating configuration
module amc_axis_motion_config #(
    parameter NUM_AXES = 8
) (
    // clock and reset
    input  wire                     pclk,
    input  wire                     presetn,
    // apb slave
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [11:0]              paddr,
    input  wire [31:0]              pwdata,
    input  wire [3:0]               pstrb,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    // motion inputs: per-axis move direction and one estop shared by all axes
    input  wire [NUM_AXES-1:0]      move_positive,
    input  wire                     estop_n,
    // per-axis outputs toward drivers
    output reg  [NUM_AXES-1:0]      motor_dir_ff,
    output reg  [NUM_AXES-1:0]      winding_on_ff,
    output reg  [NUM_AXES-1:0]      homing_enable_ff,
    output reg  [NUM_AXES*8-1:0]    step_div_ff,
    output reg  [NUM_AXES*10-1:0]   step_rate_ff,
    output reg  [NUM_AXES*27-1:0]   home_offset_ff,
    output reg  [NUM_AXES*3-1:0]    home_method_ff
);

    // ============================================================
    // storage
    // settings live in flops; retention across power loss belongs to the outer nonvolatile store
    reg [7:0]  div_ff   [0:NUM_AXES-1];
    reg [9:0]  rate_ff  [0:NUM_AXES-1];
    reg        dirn_ff  [0:NUM_AXES-1];
    reg [2:0]  home_ff  [0:NUM_AXES-1];
    reg [26:0] hofs_ff  [0:NUM_AXES-1];
    reg        hold_ff  [0:NUM_AXES-1];
    reg        rej_ff;
    reg [2:0]  estop_sync_ff;

    // ============================================================
    // address decode
    function [2:0] reg_group;
        input [11:0] addr;
        begin
            reg_group = addr[7:5];
        end
    endfunction

    wire [2:0]  wr_axis  = paddr[4:2];
    wire [2:0]  grp      = reg_group(paddr);
    wire        in_map   = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) &&
                           ((grp <= 3'h5) || (paddr == `AMC_STAT_ADDR));
    wire        access   = psel && penable && pready;
    wire        wr_en    = access && pwrite && in_map;
    wire        full_wr  = (pstrb == 4'hF);

    wire        div_ok;
    wire        rate_ok  = (pwdata[31:10] == 22'h000000) && (pwdata[9:0] != 10'h000) &&
                           (pwdata[9:0] <= `AMC_RATE_MAX);
    wire        home_ok  = (pwdata[31:3] == 29'h00000000) && (pwdata[2:0] <= `AMC_HOME_MAX);
    wire        hofs_ok  = (pwdata[31:27] == 5'h00) && (pwdata[26:0] <= `AMC_HOFS_MAX);
    wire        bit_ok   = (pwdata[31:1] == 31'h00000000);

    amc_div_check u_div_check (
        .factor (pwdata[7:0]),
        .legal  (div_ok)
    );

    wire div_legal = div_ok && (pwdata[31:8] == 24'h000000);

    reg  value_ok;
    always @* begin
        case (grp)
            3'h0: value_ok = div_legal;
            3'h1: value_ok = rate_ok;
            3'h2: value_ok = bit_ok;
            3'h3: value_ok = home_ok;
            3'h4: value_ok = hofs_ok;
            3'h5: value_ok = bit_ok;
            default: value_ok = 1'b1;
        endcase
    end

    wire store = wr_en && full_wr && value_ok && (grp <= 3'h5);
    wire bad_wr = wr_en && (grp <= 3'h5) && !(full_wr && value_ok);

    // ============================================================
    // apb handshake: one wait state, answer in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready &&
                       (!in_map || (pwrite && (grp <= 3'h5) && !(full_wr && value_ok)));
            prdata  <= 32'h00000000;
            if (psel && penable && !pready && !pwrite && in_map) begin
                case (grp)
                    3'h0: prdata <= {24'h000000, div_ff[wr_axis]};
                    3'h1: prdata <= {22'h000000, rate_ff[wr_axis]};
                    3'h2: prdata <= {31'h00000000, dirn_ff[wr_axis]};
                    3'h3: prdata <= {29'h00000000, home_ff[wr_axis]};
                    3'h4: prdata <= {5'h00, hofs_ff[wr_axis]};
                    3'h5: prdata <= {31'h00000000, hold_ff[wr_axis]};
                    default: prdata <= {31'h00000000, rej_ff};
                endcase
            end
        end
    end

    // ============================================================
    // status: sticky reject flag, cleared by writing one to it
    wire clr_rej = wr_en && (paddr == `AMC_STAT_ADDR) && pwdata[`AMC_STAT_REJ_BIT];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rej_ff <= 1'b0;
        end else if (bad_wr) begin
            rej_ff <= 1'b1;
        end else if (clr_rej) begin
            rej_ff <= 1'b0;
        end
    end

    // estop arrives from a pin: three flops, change counts when last two agree
    reg estop_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            estop_sync_ff <= 3'b111;
            estop_ff      <= 1'b0;
        end else begin
            estop_sync_ff <= {estop_sync_ff[1:0], estop_n};
            if (estop_sync_ff[2] == estop_sync_ff[1]) begin
                estop_ff <= !estop_sync_ff[2];
            end
        end
    end

    // ============================================================
    // per-axis settings and outputs
    genvar a;
    generate
        for (a = 0; a < NUM_AXES; a = a + 1) begin : g_axis
            localparam [2:0] AXIS_ID = a;
            wire        sel = store && (wr_axis == AXIS_ID);
            wire        dir_w;
            wire        hen_w;
            wire [26:0] ofs_w;
            wire        win_w;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    div_ff[a]  <= `AMC_DIV_RST;
                    rate_ff[a] <= `AMC_RATE_RST;
                    dirn_ff[a] <= `AMC_DIRN_RST;
                    home_ff[a] <= `AMC_HOME_RST;
                    hofs_ff[a] <= `AMC_HOFS_RST;
                    hold_ff[a] <= `AMC_HOLD_RST;
                end else if (sel) begin
                    case (grp)
                        3'h0: div_ff[a]  <= pwdata[7:0];
                        3'h1: rate_ff[a] <= pwdata[9:0];
                        3'h2: dirn_ff[a] <= pwdata[0];
                        3'h3: home_ff[a] <= pwdata[2:0];
                        3'h4: hofs_ff[a] <= pwdata[26:0];
                        3'h5: hold_ff[a] <= pwdata[0];
                        default: hold_ff[a] <= hold_ff[a];
                    endcase
                end
            end

            amc_axis_cmd u_cmd (
                .rotation_negative    (dirn_ff[a]),
                .homing_method_select (home_ff[a]),
                .homing_offset        (hofs_ff[a]),
                .estop_winding_hold   (hold_ff[a]),
                .move_positive        (move_positive[a]),
                .estop                (estop_ff),
                .motor_dir            (dir_w),
                .homing_enable        (hen_w),
                .offset_used          (),
                .offset_eff           (ofs_w),
                .winding_on           (win_w)
            );

            // registered copies feed pulse generation and homing; travel per step feeds distance conversion
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    motor_dir_ff[a]          <= 1'b1;
                    winding_on_ff[a]         <= 1'b1;
                    homing_enable_ff[a]      <= 1'b1;
                    step_div_ff[a*8 +: 8]    <= `AMC_DIV_RST;
                    step_rate_ff[a*10 +: 10] <= `AMC_RATE_RST;
                    home_offset_ff[a*27 +: 27] <= 27'h0000000;
                    home_method_ff[a*3 +: 3] <= `AMC_HOME_RST;
                end else begin
                    motor_dir_ff[a]          <= dir_w;
                    winding_on_ff[a]         <= win_w;
                    homing_enable_ff[a]      <= hen_w;
                    step_div_ff[a*8 +: 8]    <= div_ff[a];
                    step_rate_ff[a*10 +: 10] <= rate_ff[a];
                    home_offset_ff[a*27 +: 27] <= ofs_w;
                    home_method_ff[a*3 +: 3] <= home_ff[a];
                end
            end
        end
    endgenerate

endmodule // amc_axis_motion_config

// File: verilog/amc_div_check.v
// legality check for microstep division factors
`timescale 1ns/10ps
module amc_div_check (
    // factor under test
    input  wire [7:0] factor,
    // result
    output wire       legal
);

    reg ok;

    always @* begin
        case (factor)
            8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0A, 8'h14, 8'h19,
            8'h28, 8'h32, 8'h50, 8'h64, 8'h7D, 8'hC8, 8'hFA: ok = 1'b1;
            default: ok = 1'b0;
        endcase
    end

    assign legal = ok;

endmodule // amc_div_check
